// *** verilog/pwm_gen_pkg.sv ***
// constants, field positions and types of the pwm generator mode control block
// How it works
// - dead-time field 11 runs compensation, 10 applies no dead time
// - field 01 gives negative dead time when complementary, 00 positive always
// - polarity set: low compensation input shortens low, lengthens high; high reverses
// - polarity bit acts only in compensation mode, ignored otherwise
// - time-base select one takes secondary master base, zero the primary
// - alignment bit one counts center-aligned, zero edge-aligned
// - center alignment needs independent time base, else alignment bit ignored
// - external reset bit lets current-limit source restart independent time base while current-limit mode is clear
// - immediate update bit applies duty, phase, dead times now, else at boundary
// - control bit four is unimplemented and reads zero
package pwm_gen_pkg;
  localparam int DATA_W = 16;
  localparam int ADR_W = 5;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [ADR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADR_W-1:0] OFS_DUTY = 5'h04;
  localparam logic [ADR_W-1:0] OFS_PHASE = 5'h08;
  localparam logic [ADR_W-1:0] OFS_PERIOD = 5'h0C;
  localparam logic [ADR_W-1:0] OFS_DT = 5'h10;
  localparam logic [ADR_W-1:0] OFS_ALT_DT = 5'h14;
  localparam logic [ADR_W-1:0] OFS_STATUS = 5'h18;
  localparam logic [ADR_W-1:0] OFS_MASK = 5'h1C;
  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int B_IUE = 0;
  localparam int B_EXTERNAL_PERIOD_RESET_ENABLE = 1;
  localparam int B_CAM = 2;
  localparam int B_MASTER_TIMEBASE_SELECT = 3;
  localparam int B_COMPENSATION_POLARITY = 5;
  localparam int B_DTC_LO = 6;
  localparam int B_DTC_HI = 7;
  localparam int B_ITB = 8;
  localparam int B_EN = 9;
  localparam int B_CMPL = 10;
  localparam int B_CURRENT_LIMIT_MODE = 11;
  localparam logic [DATA_W-1:0] CTRL_WMASK = 16'h0FEF;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] PERIOD_RESET = 16'h00FF;
  // ----------------------------------------
  // status bits
  // ----------------------------------------
  localparam int ST_W = 2;
  localparam int ST_BOUND = 0;
  localparam int ST_XRST = 1;
  typedef enum logic [1:0] {
    DTC_POS = 2'h0,
    DTC_NEG = 2'h1,
    DTC_OFF = 2'h2,
    DTC_COMP = 2'h3
  } dtc_type;
  typedef enum logic [1:0] {
    DIR_UP = 2'h1,
    DIR_DOWN = 2'h2
  } dir_type;
endpackage : pwm_gen_pkg

// *** verilog/dead_time_shaper.sv ***
// dead-time and compensation shaping of one raw pwm wave into high and low outputs
`timescale 1ns/10ps
`default_nettype none
module dead_time_shaper #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic raw,
  input wire logic enable,
  input wire pwm_gen_pkg::dtc_type dead_time_control,
  input wire logic comp_pol,
  input wire logic comp_in,
  input wire logic complementary,
  input wire logic [W-1:0] dt,
  input wire logic [W-1:0] alt_dt,
  output logic high,
  output logic low
);
  import pwm_gen_pkg::*;
  typedef struct packed {
    logic prev;
    logic [W-1:0] since;
    logic high;
    logic low;
  } shp_type;
  shp_type s;
  shp_type next_s;
  logic shorten_low;

  always_comb begin
    next_s = s;
    next_s.prev = raw;
    if (raw != s.prev) begin
      next_s.since = '0;
    end else if (s.since != {W{1'b1}}) begin
      next_s.since = s.since + 1'b1;
    end
    // polarity only consulted in the compensation branch
    shorten_low = comp_pol ? !comp_in : comp_in;
    case (dead_time_control)
      DTC_POS: begin
        next_s.high = raw && (next_s.since >= dt);
        next_s.low = !raw && (next_s.since >= alt_dt);
      end
      DTC_NEG: begin
        next_s.high = raw || (complementary && next_s.since < dt);
        next_s.low = !raw || (complementary && next_s.since < alt_dt);
      end
      DTC_COMP: begin
        if (shorten_low) begin
          next_s.high = raw || (next_s.since < dt);
          next_s.low = !raw && (next_s.since >= dt);
        end else begin
          next_s.high = raw && (next_s.since >= dt);
          next_s.low = !raw || (next_s.since < dt);
        end
      end
      default: begin
        next_s.high = raw;
        next_s.low = !raw;
      end
    endcase
    if (!enable) begin
      next_s.high = 1'b0;
      next_s.low = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign high = s.high;
  assign low = s.low;

  chk_no_dead_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (enable && dead_time_control == DTC_OFF) |=> (high == $past(raw) && low == !$past(raw)))
    else $error("disabled dead time does not pass the raw wave");
  chk_positive_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (enable && dead_time_control == DTC_POS) |=> !(high && low))
    else $error("positive dead time lets both outputs overlap");
  chk_comp_pol_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (enable && dead_time_control == DTC_COMP && comp_pol && !comp_in && raw) |=> (high && !low))
    else $error("compensation with polarity set did not shorten low");
  chk_comp_pol_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (enable && dead_time_control == DTC_COMP && !comp_pol && !comp_in && !raw) |=> (!high && low))
    else $error("compensation with polarity clear did not shorten high");
endmodule : dead_time_shaper
`default_nettype wire

// *** verilog/pwm_deadtime_mode_control.sv ***
// pwm generator with mode control register, time base, buffered updates and wishbone slave
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module pwm_deadtime_mode_control #(
  parameter int CNT_W = pwm_gen_pkg::DATA_W,
  parameter bit HAS_SECONDARY = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pwm_gen_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic primary_tb_tick,
  input wire logic primary_tb_sync,
  input wire logic secondary_tb_tick,
  input wire logic secondary_tb_sync,
  input wire logic current_limit_pin,
  input wire logic compensation_input,
  output logic pwm_high_output,
  output logic pwm_low_output,
  output logic irq
);
  import pwm_gen_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic cl_meta;
    logic cl_sync;
    logic cl_prev;
    logic cmp_meta;
    logic cmp_sync;
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] duty;
    logic [DATA_W-1:0] phase;
    logic [DATA_W-1:0] period;
    logic [DATA_W-1:0] dt;
    logic [DATA_W-1:0] alt_dt;
    logic [DATA_W-1:0] act_duty;
    logic [DATA_W-1:0] act_phase;
    logic [DATA_W-1:0] act_period;
    logic [DATA_W-1:0] act_dt;
    logic [DATA_W-1:0] act_alt_dt;
    logic [CNT_W-1:0] cnt;
    dir_type dir;
    logic raw;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic ack;
    logic [31:0] dat;
  } ctl_type;

  ctl_type s;
  ctl_type next_s;

  logic req;
  logic wr_take;
  logic rd_take;
  logic enable;
  logic independent_timebase;
  logic center;
  logic use_secondary;
  logic tick;
  logic msync;
  logic ext_reset;
  logic boundary;
  logic load;
  logic [ST_W-1:0] events;
  logic [DATA_W-1:0] rd_val;

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old,
    input logic [31:0] data,
    input logic [3:0] sel
  );
    logic [DATA_W-1:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = data[7:0];
    end
    if (sel[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction : merge

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign enable = s.ctrl[B_EN];
  assign independent_timebase = s.ctrl[B_ITB];
  // alignment bit has no effect unless the generator owns its time base
  assign center = s.ctrl[B_CAM] && independent_timebase;
  // without a secondary base the select bit falls back to the primary
  assign use_secondary = s.ctrl[B_MASTER_TIMEBASE_SELECT] && HAS_SECONDARY;
  assign tick = independent_timebase ? 1'b1 : (use_secondary ? secondary_tb_tick : primary_tb_tick);
  assign msync = !independent_timebase && (use_secondary ? secondary_tb_sync : primary_tb_sync);
  // does not rely on software having cleared current-limit mode first; the bit is gated here
  assign ext_reset = s.ctrl[B_EXTERNAL_PERIOD_RESET_ENABLE] && independent_timebase && !s.ctrl[B_CURRENT_LIMIT_MODE]
    && s.cl_sync && !s.cl_prev;

  always_comb begin
    boundary = 1'b0;
    if (enable && tick && !msync && !ext_reset) begin
      if (center) begin
        boundary = (s.dir == DIR_DOWN) && (s.cnt == '0);
      end else begin
        boundary = (s.cnt >= s.act_period[CNT_W-1:0]);
      end
    end
  end

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_take = req && s.ack && wb_we_i;
  assign rd_take = req && s.ack && !wb_we_i;

  always_comb begin
    case (wb_adr_i)
      OFS_CTRL: rd_val = s.ctrl & CTRL_WMASK;
      OFS_DUTY: rd_val = s.duty;
      OFS_PHASE: rd_val = s.phase;
      OFS_PERIOD: rd_val = s.period;
      OFS_DT: rd_val = s.dt;
      OFS_ALT_DT: rd_val = s.alt_dt;
      OFS_STATUS: rd_val = {{(DATA_W-ST_W){1'b0}}, s.status};
      OFS_MASK: rd_val = {{(DATA_W-ST_W){1'b0}}, s.mask};
      default: rd_val = '0;
    endcase
  end

  assign events = {ext_reset && enable, boundary};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.cl_meta = current_limit_pin;
    next_s.cl_sync = s.cl_meta;
    next_s.cl_prev = s.cl_sync;
    next_s.cmp_meta = compensation_input;
    next_s.cmp_sync = s.cmp_meta;
    next_s.ack = req && !s.ack;
    next_s.dat = (req && !s.ack) ? {16'h0000, rd_val} : 32'h0000_0000;
    if (wr_take) begin
      case (wb_adr_i)
        OFS_CTRL: next_s.ctrl = merge(s.ctrl, wb_dat_i, wb_sel_i) & CTRL_WMASK;
        OFS_DUTY: next_s.duty = merge(s.duty, wb_dat_i, wb_sel_i);
        OFS_PHASE: next_s.phase = merge(s.phase, wb_dat_i, wb_sel_i);
        OFS_PERIOD: next_s.period = merge(s.period, wb_dat_i, wb_sel_i);
        OFS_DT: next_s.dt = merge(s.dt, wb_dat_i, wb_sel_i);
        OFS_ALT_DT: next_s.alt_dt = merge(s.alt_dt, wb_dat_i, wb_sel_i);
        OFS_MASK: next_s.mask = ST_W'(merge({{(DATA_W-ST_W){1'b0}}, s.mask},
          wb_dat_i, wb_sel_i));
        default: next_s.ctrl = s.ctrl;
      endcase
    end
    // reading status clears it, but an event in the same cycle survives
    if (rd_take && wb_adr_i == OFS_STATUS) begin
      next_s.status = events;
    end else begin
      next_s.status = s.status | events;
    end
    // active copies follow the buffers at once, at the period boundary, or while disabled
    load = next_s.ctrl[B_IUE] || boundary || !enable;
    if (load) begin
      next_s.act_duty = next_s.duty;
      next_s.act_phase = next_s.phase;
      next_s.act_period = next_s.period;
      next_s.act_dt = next_s.dt;
      next_s.act_alt_dt = next_s.alt_dt;
    end
    // ----------------------------------------
    // time base
    // ----------------------------------------
    if (!enable || msync || ext_reset) begin
      next_s.cnt = s.act_phase[CNT_W-1:0];
      next_s.dir = DIR_UP;
    end else if (tick) begin
      case (s.dir)
        DIR_UP: begin
          if (s.cnt >= s.act_period[CNT_W-1:0]) begin
            if (center) begin
              next_s.dir = DIR_DOWN;
              next_s.cnt = s.cnt - 1'b1;
            end else begin
              next_s.cnt = '0;
            end
          end else begin
            next_s.cnt = s.cnt + 1'b1;
          end
        end
        DIR_DOWN: begin
          if (!center || s.cnt == '0) begin
            next_s.dir = DIR_UP;
            next_s.cnt = center ? s.cnt + 1'b1 : '0;
          end else begin
            next_s.cnt = s.cnt - 1'b1;
          end
        end
        default: begin
          next_s.dir = DIR_UP;
          next_s.cnt = '0;
        end
      endcase
    end
    next_s.raw = enable && (next_s.cnt < s.act_duty[CNT_W-1:0]);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.period <= PERIOD_RESET;
      s.act_period <= PERIOD_RESET;
      s.dir <= DIR_UP;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // output shaping
  // ----------------------------------------
  dead_time_shaper #(
    .W(DATA_W)
  ) u_shaper (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw(s.raw),
    .enable(enable),
    .dead_time_control(dtc_type'(s.ctrl[B_DTC_HI:B_DTC_LO])),
    .comp_pol(s.ctrl[B_COMPENSATION_POLARITY]),
    .comp_in(s.cmp_sync),
    .complementary(s.ctrl[B_CMPL]),
    .dt(s.act_dt),
    .alt_dt(s.act_alt_dt),
    .high(pwm_high_output),
    .low(pwm_low_output)
  );

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign irq = |(s.status & s.mask);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_bit4_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wb_ack_o && !wb_we_i && wb_adr_i == OFS_CTRL) |-> !wb_dat_o[4])
    else $error("control bit four read back as one");
  chk_immediate_duty: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_take && wb_adr_i == OFS_DUTY && wb_sel_i[1:0] == 2'b11 && s.ctrl[B_IUE])
    |=> s.act_duty == $past(wb_dat_i[15:0]))
    else $error("immediate duty update did not reach the active copy");
  chk_buffered_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (enable && !s.ctrl[B_IUE] && !boundary && !(wr_take && wb_adr_i == OFS_CTRL))
    |=> $stable(s.act_duty))
    else $error("buffered duty changed away from the period boundary");
  chk_edge_direction: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !center |=> s.dir == DIR_UP || $past(center))
    else $error("counter reversed while center alignment is off");
  chk_external_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (enable && ext_reset) |=> (s.cnt == $past(s.act_phase) && s.status[ST_XRST]))
    else $error("current-limit restart did not reload the time base");
  chk_no_ext_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s.ctrl[B_EXTERNAL_PERIOD_RESET_ENABLE] |-> !ext_reset)
    else $error("time base restarted with external reset off");
  chk_master_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (enable && !independent_timebase && (s.ctrl[B_MASTER_TIMEBASE_SELECT] ? secondary_tb_sync : primary_tb_sync))
    |=> s.cnt == $past(s.act_phase))
    else $error("selected master base sync did not restart the count");
  chk_status_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (boundary && s.mask[ST_BOUND]) |=> irq [*2])
    else $error("boundary event did not raise the interrupt");
endmodule : pwm_deadtime_mode_control
`default_nettype wire

// *** verification/power_stage_model.sv ***
// power stage model: senses load current direction and flags overlapping gate drive
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
  input wire logic ref_clk,
  input wire logic gate_high,
  input wire logic gate_low,
  input wire logic current_dir,
  output logic current_sense,
  output logic shoot_through
);
  // the sense comparator lags the load current by one clock, as real hardware does
  always_ff @(posedge ref_clk) begin
    current_sense <= current_dir;
    shoot_through <= gate_high & gate_low;
  end
endmodule : power_stage_model
`default_nettype wire

// *** verification/pwm_deadtime_mode_control_bench.sv ***
// self-checking bench of the pwm generator mode control block
`timescale 1ns/10ps
`default_nettype none
module pwm_deadtime_mode_control_bench;
  import pwm_gen_pkg::*;
  localparam int P = 19;
  localparam int D = 10;
  localparam int DT = 2;
  localparam int ADT = 3;
  localparam int W = 12 * (P + 1);
  localparam int INDEPENDENT_TIMEBASE = 1 << B_ITB;
  localparam int CMP = 1 << B_CMPL;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, irq, comp_in, hi_out, lo_out, both_on;
  logic p_tick = 1'b0;
  logic p_sync = 1'b0;
  logic s_tick = 1'b0;
  logic clim = 1'b0;
  logic cur_dir = 1'b0;
  logic [15:0] q;
  int err_total = 0;
  int checked = 0;
  int hi, lo, ri, bo;
  always #2 ref_clk = ~ref_clk;
  pwm_deadtime_mode_control dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .primary_tb_tick(p_tick), .primary_tb_sync(p_sync), .secondary_tb_tick(s_tick),
    .secondary_tb_sync(1'b0), .current_limit_pin(clim), .compensation_input(comp_in),
    .pwm_high_output(hi_out), .pwm_low_output(lo_out), .irq(irq)
  );
  power_stage_model stage (
    .ref_clk(ref_clk), .gate_high(hi_out), .gate_low(lo_out), .current_dir(cur_dir),
    .current_sense(comp_in), .shoot_through(both_on)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // request held until ack is sampled high; read data taken at that same edge
  task automatic wb(input logic [ADR_W-1:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_total++;
      $display("[FAIL] bus ack expected 1 seen %b", ack);
    end
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // mode bits change only while disabled, then 12 * (P + 1) clocks are measured, twelve edge-aligned periods with a tick every clock
  task automatic run(input int c);
    logic p;
    wb(OFS_CTRL, 1'b1, 16'(c & ~(1 << B_EN)));
    wb(OFS_CTRL, 1'b1, 16'(c | (1 << B_EN)));
    repeat (80) @(posedge ref_clk);
    hi = 0;
    lo = 0;
    ri = 0;
    bo = 0;
    p = hi_out;
    repeat (W) begin
      @(posedge ref_clk);
      hi += (hi_out === 1'b1);
      lo += (lo_out === 1'b1);
      bo += (both_on === 1'b1);
      ri += (hi_out === 1'b1 && p === 1'b0);
      p = hi_out;
    end
  endtask : run
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    check("idle_high", hi_out, 1'b0);
    check("idle_low", lo_out, 1'b0);
    wb(OFS_CTRL, 1'b0, 16'h0000);
    check("ctrl_reset", q, CTRL_RESET);
    wb(OFS_PERIOD, 1'b0, 16'h0000);
    check("period_reset", q, PERIOD_RESET);
    wb(OFS_MASK, 1'b0, 16'h0000);
    check("mask_reset", q, 16'h0000);
    wb(OFS_CTRL, 1'b1, 16'hFFFF);
    wb(OFS_CTRL, 1'b0, 16'h0000);
    check("ctrl_bits", q, CTRL_WMASK);
    check("ctrl_bit4", q[4], 1'b0);
    wb(5'h02, 1'b1, 16'hFFFF);
    wb(5'h02, 1'b0, 16'h0000);
    check("unmapped", q, 16'h0000);
    wb(OFS_CTRL, 1'b1, 16'h0000);
    wb(OFS_PERIOD, 1'b1, 16'(P));
    wb(OFS_DUTY, 1'b1, 16'(D));
    wb(OFS_DT, 1'b1, 16'(DT));
    wb(OFS_ALT_DT, 1'b1, 16'(ADT));
  endtask : t_regs
  task automatic t_dtc;
    int eh[3];
    int el[3];
    int eo[3];
    eh = '{12 * (D - DT), 12 * (D + DT), 12 * D};
    el = '{12 * (P + 1 - D - ADT), 12 * (P + 1 - D + ADT), 12 * (P + 1 - D)};
    eo = '{0, 12 * (DT + ADT), 0};
    for (int k = 0; k < 3; k++) begin
      run(INDEPENDENT_TIMEBASE | CMP | (k << B_DTC_LO));
      check("dt_high", hi, eh[k]);
      check("dt_low", lo, el[k]);
      check("overlap", bo, eo[k]);
      check("edge_rises", ri, 12);
    end
  endtask : t_dtc
  task automatic t_comp;
    int h[2];
    for (int pol = 0; pol < 2; pol++) begin
      for (int c = 0; c < 2; c++) begin
        cur_dir <= c[0];
        run(INDEPENDENT_TIMEBASE | CMP | (3 << B_DTC_LO) | (pol << B_COMPENSATION_POLARITY));
        h[c] = hi;
      end
      check("comp_side", h[0] > h[1], pol[0]);
    end
    for (int pol = 0; pol < 2; pol++) begin
      run(INDEPENDENT_TIMEBASE | CMP | (pol << B_COMPENSATION_POLARITY));
      h[pol] = hi;
    end
    check("pol_ignored", h[0] == h[1], 1'b1);
  endtask : t_comp
  task automatic t_tb;
    p_tick <= 1'b1;
    run(CMP);
    check("primary_base", ri, 12);
    p_sync <= 1'b1;
    run(CMP);
    check("primary_sync", ri, 0);
    p_sync <= 1'b0;
    run(CMP | (1 << B_MASTER_TIMEBASE_SELECT));
    check("secondary_idle", ri, 0);
    p_tick <= 1'b0;
    s_tick <= 1'b1;
    run(CMP | (1 << B_MASTER_TIMEBASE_SELECT));
    check("secondary_base", ri, 12);
    run(CMP | (1 << B_MASTER_TIMEBASE_SELECT) | (1 << B_CAM));
    check("align_ignored", ri, 12);
    run(INDEPENDENT_TIMEBASE | CMP | (1 << B_CAM));
    check("center_slow", ri < 8, 1'b1);
  endtask : t_tb
  // new duty written just after the high output falls, well before the period ends
  task automatic t_iue;
    int n;
    for (int u = 0; u < 2; u++) begin
      run(INDEPENDENT_TIMEBASE | CMP | (2 << B_DTC_LO) | (u << B_IUE));
      n = 0;
      while (hi_out !== 1'b1 && n < 50) begin
        @(posedge ref_clk);
        n++;
      end
      while (hi_out !== 1'b0 && n < 100) begin
        @(posedge ref_clk);
        n++;
      end
      wb(OFS_DUTY, 1'b1, 16'(P));
      n = 0;
      repeat (3) begin
        @(posedge ref_clk);
        n += (hi_out === 1'b1);
      end
      check("immediate", n > 0, u[0]);
      wb(OFS_DUTY, 1'b1, 16'(D));
    end
  endtask : t_iue
  task automatic t_xrst;
    for (int x = 0; x < 4; x++) begin
      wb(OFS_MASK, 1'b1, (x == 3) ? 16'h0000 : 16'h0002);
      run(INDEPENDENT_TIMEBASE | CMP | ((x > 0) << B_EXTERNAL_PERIOD_RESET_ENABLE) | ((x == 2) << B_CURRENT_LIMIT_MODE));
      wb(OFS_STATUS, 1'b0, 16'h0000);
      clim <= 1'b1;
      repeat (4) @(posedge ref_clk);
      clim <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check("xrst_irq", irq, x == 1);
      wb(OFS_STATUS, 1'b0, 16'h0000);
      check("xrst_flag", q[ST_XRST], x == 1 || x == 3);
      repeat (2) @(posedge ref_clk);
      check("irq_cleared", irq, 1'b0);
    end
  endtask : t_xrst
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_dtc();
    t_comp();
    t_tb();
    t_iue();
    t_xrst();
    end_sim();
  end
  initial begin
    #200000;
    err_total++;
    $display("[FAIL] watchdog expected finish seen timeout");
    end_sim();
  end
endmodule : pwm_deadtime_mode_control_bench
`default_nettype wire
